// ===== sdli_pkg.sv
// How it works
// - low frame sync enables input shifting
// - sixteen bits sampled on falling clock edges
// - update strobe low copies all data registers
// - update low at sixteenth edge autoupdates
// - clear forces main dacs to cleared code
// - clear also resets every sub dac
// - power down low enters low power mode
// - external reference selected per channel by control word bit 0
package sdli_pkg;
  localparam int          WORD_BITS    = 16;              // serial word length
  localparam int          CODE_BITS    = 10;              // dac code width
  localparam int          SUB_BITS     = 4;               // sub dac trim width
  localparam int          ADDR_LSB     = 12;              // channel address field position
  localparam int          ADDR_BITS    = 3;               // channel address width
  localparam int          CTRL_BIT     = 11;              // set: control word, clear: data word
  localparam int          REFSEL_BIT   = 0;               // control word: external ref select
  localparam int          CLRSEL_BIT   = 1;               // control word: clear to bias/16
  localparam int          SUB_LSB      = 2;               // control word: sub dac field
  localparam logic [9:0]  CLEAR_CODE   = 10'h200;         // cleared code, bias level
  localparam logic [9:0]  CLEAR_CODE16 = 10'h020;         // cleared code, bias/16 level
  localparam logic [9:0]  RESET_CODE   = 10'h200;         // value after reset
  localparam logic [3:0]  SUB_RESET    = 4'h0;            // sub dac after reset or clear
  localparam logic [4:0]  EDGE_LAST    = 5'h10;           // sixteenth falling edge count
  localparam int          FIFO_DEPTH   = 8;               // word buffer depth
endpackage

// ===== sdli_top.sv
`timescale 1ns/100ps
`default_nettype none
// word fifo with valid and ready on both sides
module sdli_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);   // pointer width without the wrap bit
  // elaboration check: pointer wrap needs a power of two depth
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end
  // elaboration check: a word needs at least one bit
  if (W < 1) begin : g_bad_width
    $error("fifo width must be at least one");
  end
  logic [W-1:0] mem [D];   // word storage
  logic [AW:0]  wr_ptr;    // write pointer with wrap bit
  logic [AW:0]  rd_ptr;    // read pointer with wrap bit
  wire          push = in_valid_i && in_ready_o;
  wire          pop  = out_valid_o && out_ready_i;
  wire          full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  // fill side refuses when full, drain side shows the oldest word
  assign in_ready_o  = !full;
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  // storage write
  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data_i;
  end
  // pointers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// serial dac load interface, device side
module sdli_top
#(
  parameter int CHANNELS = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  frame_sync_n_i,
  input  wire logic                  serial_clock_in_i,
  input  wire logic                  serial_data_in_i,
  input  wire logic                  dac_update_n_i,
  input  wire logic                  async_clear_n_i,
  input  wire logic                  power_down_n_i,
  output logic [CHANNELS*sdli_pkg::CODE_BITS-1:0] dac_code_o,
  output logic [CHANNELS*sdli_pkg::SUB_BITS-1:0]  sub_code_o,
  output logic [CHANNELS-1:0]        ext_ref_sel_o,
  output logic                       low_power_o,
  output logic                       word_done_o
);
  import sdli_pkg::*;
  // elaboration check: the address field reaches eight channels at most
  if (CHANNELS < 1 || CHANNELS > (1 << ADDR_BITS)) begin : g_bad_channels
    $error("channels must be 1 to 8");
  end
  // two-flop synchronisers: fs, sclk, serial_data_in, update, clear, power down
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic       sclk_d;          // previous synced serial clock
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sync1  <= 6'h3b;
      sync2  <= 6'h3b;
      sclk_d <= 1'b1;          // idle level, so no false edge after reset
    end else begin
      sync1  <= {power_down_n_i, async_clear_n_i, dac_update_n_i,
                 serial_data_in_i, serial_clock_in_i, frame_sync_n_i};
      sync2  <= sync1;
      sclk_d <= sync2[1];
    end
  end
  wire fs_n     = sync2[0];
  wire sclk     = sync2[1];
  wire serial_data_in     = sync2[2];
  wire upd_n    = sync2[3];
  wire clr_n    = sync2[4];
  wire pd_n     = sync2[5];
  wire sclk_fall = sclk_d && !sclk;
  wire shift_en  = !fs_n && sclk_fall;

  // input shift register and edge counter
  logic [WORD_BITS-1:0] shreg;
  logic [4:0]           edge_cnt;
  wire  [WORD_BITS-1:0] next_shreg = {shreg[WORD_BITS-2:0], serial_data_in};
  wire                  last_edge  = shift_en && (edge_cnt == EDGE_LAST - 5'h01);
  // frame high drops a partial word and restarts the count
  always_ff @(posedge clk_i) begin
    if (!resetn_i || fs_n) begin
      edge_cnt <= 5'h00;
    end else if (shift_en && edge_cnt != EDGE_LAST) begin
      shreg    <= next_shreg;
      edge_cnt <= edge_cnt + 5'h01;
    end
  end
  // word goes into fifo with its update sample as bit 16
  logic        push_pend;
  logic [16:0] push_word;
  wire         fifo_in_ready;
  wire         fifo_out_valid;
  wire [16:0]  fifo_out_data;
  // pending word waits for the fifo; a new word wins over the clear
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      push_pend <= 1'b0;
      push_word <= 17'h00000;
    end else if (last_edge) begin
      push_pend <= 1'b1;
      push_word <= {!upd_n, next_shreg};
    end else if (fifo_in_ready) begin
      push_pend <= 1'b0;
    end
  end
  // drain side always ready, so the buffer never stalls the link
  sdli_fifo #(.W(17), .D(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (push_pend),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (1'b1),
    .out_data_o  (fifo_out_data)
  );
  // decode of popped word
  wire [ADDR_BITS-1:0] w_addr = fifo_out_data[ADDR_LSB +: ADDR_BITS];
  wire                 w_ctrl = fifo_out_data[CTRL_BIT];
  wire                 w_auto = fifo_out_data[16];
  wire [CODE_BITS-1:0] w_code = fifo_out_data[CODE_BITS-1:0];
  // update: pin level, or the auto flag carried along with the word
  wire                 update = !upd_n || (fifo_out_valid && w_auto);

  // per channel data, dac, sub and control registers
  logic [CODE_BITS-1:0] data_reg [CHANNELS];
  logic [CODE_BITS-1:0] dac_reg  [CHANNELS];
  logic                 clr16    [CHANNELS];
  // a data word arriving during an update goes straight to its dac
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      wire hit = fifo_out_valid && (w_addr == ADDR_BITS'(g));
      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          data_reg[g] <= RESET_CODE;
          dac_reg[g]  <= RESET_CODE;
          clr16[g]    <= 1'b0;
          sub_code_o[g*SUB_BITS +: SUB_BITS] <= SUB_RESET;
          ext_ref_sel_o[g] <= 1'b0;
        end else if (!clr_n) begin
          // clear is synchronised: it lands two to three clocks after the pin
          dac_reg[g] <= clr16[g] ? CLEAR_CODE16 : CLEAR_CODE;
          sub_code_o[g*SUB_BITS +: SUB_BITS] <= SUB_RESET;
        end else begin
          if (hit && !w_ctrl) data_reg[g] <= w_code;
          if (hit && w_ctrl) begin
            ext_ref_sel_o[g] <= fifo_out_data[REFSEL_BIT];
            clr16[g]         <= fifo_out_data[CLRSEL_BIT];
            sub_code_o[g*SUB_BITS +: SUB_BITS] <= fifo_out_data[SUB_LSB +: SUB_BITS];
          end
          if (update) dac_reg[g] <= (hit && !w_ctrl) ? w_code : data_reg[g];
        end
      end
      assign dac_code_o[g*CODE_BITS +: CODE_BITS] = dac_reg[g];
    end
  endgenerate
  // power down and word strobe
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      low_power_o <= 1'b0;
      word_done_o <= 1'b0;
    end else begin
      low_power_o <= !pd_n;
      word_done_o <= last_edge;
    end
  end

  // checks on the guarded logic
  a_shift_gated: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fs_n |=> edge_cnt == 5'h00) else $error("edge count not reset by frame");
  a_word_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    edge_cnt <= EDGE_LAST) else $error("edge count beyond word");
  a_update_copy: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!upd_n && clr_n && !fifo_out_valid) |=> dac_reg[0] == $past(data_reg[0]))
    else $error("update did not copy");
  a_auto_upd: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (last_edge && !upd_n) |=> push_word[16]) else $error("auto flag lost");
  a_clear_main: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !clr_n |=> (dac_reg[0] == CLEAR_CODE || dac_reg[0] == CLEAR_CODE16))
    else $error("clear code wrong");
  a_clear_sub: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !clr_n |=> sub_code_o[SUB_BITS-1:0] == SUB_RESET) else $error("sub not cleared");
  a_power_down: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !pd_n |=> low_power_o) else $error("low power not entered");
  a_word_strobe: assert property (@(posedge clk_i) disable iff (!resetn_i)
    last_edge |=> word_done_o ##1 !word_done_o) else $error("word strobe wrong");
  a_ref_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !fifo_out_valid |=> $stable(ext_ref_sel_o)) else $error("ref select moved");
  c_word: cover property (@(posedge clk_i) disable iff (!resetn_i) word_done_o);
  c_auto: cover property (@(posedge clk_i) disable iff (!resetn_i) fifo_out_valid && w_auto);
  c_clear: cover property (@(posedge clk_i) disable iff (!resetn_i) !clr_n);
  // strobed update with no word in flight, and low power entry
  c_strobe: cover property (@(posedge clk_i) disable iff (!resetn_i) !upd_n && !fifo_out_valid);
  c_power: cover property (@(posedge clk_i) disable iff (!resetn_i) low_power_o);
endmodule
`default_nettype wire

// ===== sdli_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host serial port model: frame, link clock and data
module sdli_host_model (
  input  wire logic clk_i,
  output logic      fs_n_o,
  output logic      sck_o,
  output logic      sd_o
);
  // idle: frame high, clock stands high
  initial begin
    fs_n_o = 1'b1;
    sck_o  = 1'b1;
    sd_o   = 1'b0;
  end
  // n bits msb first, 800 ns link clock period
  task automatic send(input logic [15:0] w, input int n);
    @(negedge clk_i) fs_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = 15; i > 15 - n; i--) begin
      sd_o = w[i];
      repeat (4) @(negedge clk_i);
      sck_o = 1'b0; // falling edge takes the bit
      repeat (4) @(negedge clk_i);
      sck_o = 1'b1;
    end
    repeat (4) @(negedge clk_i);
    fs_n_o = 1'b1;
    sd_o = ~sd_o; // released line no longer shows last bit
  endtask
endmodule
`default_nettype wire

// ===== sdli_tb.sv
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the serial dac load interface
module testbench;
  import sdli_pkg::*;
  localparam int CH = 8;
  logic         clk_i, resetn_i, upd_n, clr_n, pd_n, low_power, word_done;
  wire logic    fs_n, sck, sd;
  logic [79:0]  dac_code;
  logic [31:0]  sub_code;
  logic [7:0]   ext_ref, exp_ref;
  logic [9:0]   dreg[CH], dac[CH];
  logic [3:0]   sub[CH];
  logic         clr16[CH];
  logic [119:0] notes[$];
  logic [31:0]  lfsr_state = 32'hb495cddb;
  logic [31:0]  v;
  int           fails = 0, checked = 0;
  wire logic [119:0] seen_all = {ext_ref, sub_code, dac_code};
  sdli_top #(.CHANNELS(CH)) uut (.clk_i(clk_i), .resetn_i(resetn_i), .frame_sync_n_i(fs_n),
    .serial_clock_in_i(sck), .serial_data_in_i(sd), .dac_update_n_i(upd_n),
    .async_clear_n_i(clr_n), .power_down_n_i(pd_n), .dac_code_o(dac_code),
    .sub_code_o(sub_code), .ext_ref_sel_o(ext_ref), .low_power_o(low_power),
    .word_done_o(word_done));
  sdli_host_model host (.clk_i(clk_i), .fs_n_o(fs_n), .sck_o(sck), .sd_o(sd));
  // random source
  function automatic logic [31:0] lfsr();
    lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h80200003)};
    return lfsr_state;
  endfunction
  // expected output vector from the bench model
  function automatic logic [119:0] snap();
    logic [119:0] s;
    s = {exp_ref, 112'h0};
    for (int c = 0; c < CH; c++) begin
      s[c*10 +: 10] = dac[c];
      s[80 + c*4 +: 4] = sub[c];
    end
    return s;
  endfunction
  task automatic check(input string what, input logic [119:0] seen, input logic [119:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one word to channel c, update pin held at u for the frame
  task automatic put(input int c, input logic ctl, input logic [9:0] w, input logic u);
    @(negedge clk_i) upd_n = u;
    if (ctl) begin
      exp_ref[c] = w[0];
      clr16[c] = w[1];
      sub[c] = w[5:2];
    end else dreg[c] = w;
    for (int k = 0; k < CH; k++) if (!u) dac[k] = dreg[k];
    notes.push_back(snap());
    host.send({1'b0, 3'(c), ctl, 1'b0, w}, 16);
    repeat (12) @(negedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // each word done pulse retires the oldest note
  always @(negedge clk_i) begin
    if (word_done === 1'b1) begin
      repeat (6) @(negedge clk_i);
      if (notes.size() == 0) check("extra word", 120'h1, 120'h0);
      else check("outputs after word", seen_all, notes.pop_front());
    end
  end
  initial begin
    {upd_n, clr_n, pd_n, resetn_i, exp_ref} = {3'h7, 1'b0, 8'h0};
    for (int c = 0; c < CH; c++) begin
      dreg[c]  = RESET_CODE;
      dac[c]   = RESET_CODE;
      sub[c]   = SUB_RESET;
      clr16[c] = 1'b0;
    end
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("reset outputs", seen_all, snap());
    $display("test reset done");
    for (int c = 0; c < CH; c++) begin
      v = lfsr();
      put(c, 1'b0, v[9:0], 1'b0);
    end
    $display("test auto update done");
    for (int c = 0; c < CH; c++) begin
      v = lfsr();
      put(c, 1'b0, v[9:0], 1'b1);
    end
    upd_n = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int c = 0; c < CH; c++) dac[c] = dreg[c];
    check("strobed update", seen_all, snap());
    upd_n = 1'b1;
    $display("test strobe done");
    for (int c = 0; c < CH; c++) begin
      v = lfsr();
      put(c, 1'b1, v[9:0] & 10'h03f, 1'b1);
    end
    host.send(16'hffff, 8);
    repeat (8) @(negedge clk_i);
    v = lfsr();
    put(3, 1'b0, v[9:0], 1'b0);
    $display("test control and partial done");
    clr_n = 1'b0;
    repeat (5) @(negedge clk_i);
    for (int c = 0; c < CH; c++) {dac[c], sub[c]} = {clr16[c] ? CLEAR_CODE16 : CLEAR_CODE, 4'h0};
    check("clear", seen_all, snap());
    clr_n = 1'b1;
    pd_n = 1'b0;
    repeat (4) @(negedge clk_i);
    check("low power on", {119'h0, low_power}, 120'h1);
    pd_n = 1'b1;
    repeat (4) @(negedge clk_i);
    check("low power off", {119'h0, low_power}, 120'h0);
    $display("test clear and power done");
    complete_run();
  end
  // watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
